/* File: design/fmc_pkg.sv */
// Constants, types and register map of the fan monitor configuration block
// Function
// R01: Config six bit 0: fan 1 smoothing x4
// R02: Config six bit 1: fan 2 smoothing x4
// R03: Config six bit 2: fan 3 smoothing x4
// R04: Config six bit 3: overtemp pin in manual
// R05: Config six bit 4: sync follower unit
// R06: Config six bit 5: sync leader unit
// R07: Core low in standby: status, alert, hot-monitor off
// R08: Core recovers: hot-monitor on, spin-up, restore fans
// R09: Config six bit 7: smoothing +39.2 percent
// R10: Overtemperature event overrides every fan setting; code forces fans only while the overtemp pin is active (R04)
// R11: Config seven bit 0 disables overtemp hysteresis
// R12: Host never writes config seven bits 7:1
// R13: Lock set: config seven ignores writes
// R14: Config six resets to zero
// R15: Five voltage upper bytes at 0x20-0x24
// R16: Extended read freezes readings until upper read
// R17: Write-once lock holds lockable registers until reset
package fmc_pkg;

	// Register indices; the byte address is four times the index
	localparam int unsigned     IDX_W        = 8;
	localparam int unsigned     ADDR_LSB     = 2;
	localparam int unsigned     HADDR_W      = 32;
	localparam logic [7:0]      IDX_FAN_CFG  = 8'h10;
	localparam logic [7:0]      IDX_HYST_CFG = 8'h11;
	localparam logic [7:0]      IDX_V2V5     = 8'h20;
	localparam logic [7:0]      IDX_VCORE    = 8'h21;
	localparam logic [7:0]      IDX_VSUP     = 8'h22;
	localparam logic [7:0]      IDX_V5       = 8'h23;
	localparam logic [7:0]      IDX_V12      = 8'h24;
	localparam logic [7:0]      IDX_CFG1     = 8'h40;
	localparam logic [7:0]      IDX_STAT1    = 8'h41;
	localparam logic [7:0]      IDX_CORE_LIM = 8'h46;
	localparam logic [7:0]      IDX_MASK1    = 8'h74;
	localparam logic [7:0]      IDX_EXT1     = 8'h76;
	localparam logic [7:0]      IDX_EXT2     = 8'h77;

	// Field positions
	localparam int unsigned     FB_SLOW_RA   = 0;
	localparam int unsigned     FB_PIN_MAN   = 3;
	localparam int unsigned     FB_FOLLOWER  = 4;
	localparam int unsigned     FB_LEADER    = 5;
	localparam int unsigned     FB_CORE_LOW  = 6;
	localparam int unsigned     FB_STRETCH   = 7;
	localparam int unsigned     HB_HYST_DIS  = 0;
	localparam int unsigned     C1B_LOCK     = 1;
	localparam int unsigned     STB_CORE     = 1;

	// Reset values
	localparam logic [7:0]      RST_BYTE     = 8'h00;
	localparam logic [7:0]      RST_CORE_LIM = 8'h00;

	// Smoothing arithmetic: x4 is a shift, +39.2 percent is 1425/1024
	localparam int unsigned     FAN_N        = 3;
	localparam int unsigned     X4_SHIFT     = 2;
	localparam int unsigned     STR_NUM_W    = 11;
	localparam logic [10:0]     STR_NUM      = 11'h591;
	localparam int unsigned     STR_SHIFT    = 10;

	// Measurements: 10 bits, upper byte plus two extended bits
	localparam int unsigned     MEAS_W       = 10;
	localparam int unsigned     EXT_W        = 2;
	localparam int unsigned     VCH_N        = 5;

	// AHB-Lite encodings
	localparam logic            HRESP_OKAY   = 1'b0;

	typedef struct packed {
		logic [MEAS_W-1:0] v12;
		logic [MEAS_W-1:0] v5;
		logic [MEAS_W-1:0] supply;
		logic [MEAS_W-1:0] core;
		logic [MEAS_W-1:0] v2v5;
	} fmc_meas_t;

	typedef enum logic [0:0] {
		FMC_CORE_OK  = 1'b0,
		FMC_CORE_LOW = 1'b1
	} fmc_core_state_t;

endpackage

/* File: design/fmc_top.sv */
// AHB-Lite register bank for fan behaviour, hysteresis, lock and voltage readings
`timescale 1ns/1ps
module fmc_top #(
	parameter int unsigned  BASE_W = 16,
	localparam int unsigned OUT_W  = BASE_W + 3
) (
	input  wire logic                                CLK,
	input  wire logic                                RESET,
	input  wire logic                                HSEL,
	input  wire logic [fmc_pkg::HADDR_W-1:0]         HADDR,
	input  wire logic [1:0]                          HTRANS,
	input  wire logic                                HWRITE,
	input  wire logic [2:0]                          HSIZE,
	input  wire logic [31:0]                         HWDATA,
	input  wire logic                                HREADY,
	output logic [31:0]                              HRDATA,
	output logic                                     HREADYOUT,
	output logic                                     HRESP,
	input  wire fmc_pkg::fmc_meas_t                  MEAS,
	input  wire logic                                STANDBY_POWER,
	input  wire logic                                FAN_MANUAL,
	input  wire logic                                OVERTEMP_EVENT,
	input  wire logic [fmc_pkg::FAN_N-1:0][BASE_W-1:0] BASE_SMOOTH,
	output logic [fmc_pkg::FAN_N-1:0][OUT_W-1:0]     SMOOTH_TIME,
	output logic                                     OVERTEMP_PIN_ACTIVE,
	output logic                                     OVERTEMP_HYST_DISABLE,
	output logic                                     FAN_FORCE_MAX,
	output logic                                     SYNC_FOLLOWER,
	output logic                                     SYNC_LEADER,
	output logic                                     PROC_HOT_MONITOR_EN,
	output logic                                     SPINUP_REQ,
	output logic                                     ALERT
);

	// Refuse widths the arithmetic cannot serve
	if (BASE_W < 1 || BASE_W > 24) begin : g_bad_width
		$error("BASE_W must be 1 to 24");
	end

	// Bus state
	logic                       wr_pend;
	logic                       rd_pend;
	logic [fmc_pkg::IDX_W-1:0]  idx_q;
	logic                       mapped_q;

	// Register state
	logic [7:0]                 fan_cfg;
	logic [7:0]                 hyst_cfg;
	logic                       lock;
	logic [7:0]                 core_lim;
	logic                       mask_core;
	logic                       stat_core;
	logic [fmc_pkg::VCH_N-1:0]  pend_mask;
	fmc_pkg::fmc_meas_t         shadow;
	fmc_pkg::fmc_core_state_t   core_state;

	// Address phase decode
	wire addr_acc = HSEL & HTRANS[1] & HREADY;
	wire [fmc_pkg::IDX_W-1:0] addr_idx = HADDR[fmc_pkg::ADDR_LSB +: fmc_pkg::IDX_W];
	wire addr_top_zero = HADDR[fmc_pkg::HADDR_W-1:fmc_pkg::ADDR_LSB+fmc_pkg::IDX_W] == '0;
	wire addr_word = HADDR[fmc_pkg::ADDR_LSB-1:0] == '0;
	wire addr_mapped = addr_top_zero & addr_word;
	wire acc_read = addr_acc & ~HWRITE;
	wire acc_write = addr_acc & HWRITE;

	// Index hits for the transfer in its data phase
	wire hit_fan = mapped_q & (idx_q == fmc_pkg::IDX_FAN_CFG);
	wire hit_hyst = mapped_q & (idx_q == fmc_pkg::IDX_HYST_CFG);
	wire hit_cfg1 = mapped_q & (idx_q == fmc_pkg::IDX_CFG1);
	wire hit_stat = mapped_q & (idx_q == fmc_pkg::IDX_STAT1);
	wire hit_lim = mapped_q & (idx_q == fmc_pkg::IDX_CORE_LIM);
	wire hit_mask = mapped_q & (idx_q == fmc_pkg::IDX_MASK1);
	wire hit_ext1 = mapped_q & (idx_q == fmc_pkg::IDX_EXT1);
	wire hit_ext2 = mapped_q & (idx_q == fmc_pkg::IDX_EXT2);
	wire hit_v2v5 = mapped_q & (idx_q == fmc_pkg::IDX_V2V5);
	wire hit_vcore = mapped_q & (idx_q == fmc_pkg::IDX_VCORE);
	wire hit_vsup = mapped_q & (idx_q == fmc_pkg::IDX_VSUP);
	wire hit_v5 = mapped_q & (idx_q == fmc_pkg::IDX_V5);
	wire hit_v12 = mapped_q & (idx_q == fmc_pkg::IDX_V12);
	wire [fmc_pkg::VCH_N-1:0] hit_msb = {hit_v12, hit_v5, hit_vsup, hit_vcore, hit_v2v5};

	// Write strobes; lockable registers refuse writes once the lock is set
	wire [7:0] wbyte = HWDATA[7:0];
	wire we_fan = wr_pend & hit_fan;
	wire we_hyst = wr_pend & hit_hyst & ~lock; // R13 R17
	wire we_cfg1 = wr_pend & hit_cfg1;
	wire we_lim = wr_pend & hit_lim & ~lock; // R17
	wire we_mask = wr_pend & hit_mask;

	// Read side effects fire in the wait cycle, when the data is captured
	wire rd_ext1 = rd_pend & hit_ext1;
	wire rd_ext2 = rd_pend & hit_ext2;
	wire rd_stat = rd_pend & hit_stat;
	wire [fmc_pkg::VCH_N-1:0] rd_msb = {fmc_pkg::VCH_N{rd_pend}} & hit_msb;
	wire [fmc_pkg::VCH_N-1:0] ext_set = {rd_ext2, {(fmc_pkg::VCH_N-1){rd_ext1}}};

	// Freeze: readings hold from an extended read until each upper byte that read covers is read
	wire frozen = |pend_mask; // R16
	wire shadow_upd = ~frozen & ~rd_ext1 & ~rd_ext2; // R16
	wire [fmc_pkg::VCH_N-1:0] next_pend = (pend_mask & ~rd_msb) | ext_set; // R16
	wire fmc_pkg::fmc_meas_t next_shadow = shadow_upd ? MEAS : shadow;

	// Upper bytes and extended pairs of the frozen readings
	localparam int unsigned HI = fmc_pkg::MEAS_W - 1;
	localparam int unsigned LO = fmc_pkg::EXT_W;
	wire [7:0] msb_v2v5 = shadow.v2v5[HI:LO]; // R15
	wire [7:0] msb_core = shadow.core[HI:LO];
	wire [7:0] msb_sup = shadow.supply[HI:LO];
	wire [7:0] msb_v5 = shadow.v5[HI:LO];
	wire [7:0] msb_v12 = shadow.v12[HI:LO];
	wire [7:0] ext1_val = {shadow.v5[LO-1:0], shadow.supply[LO-1:0], shadow.core[LO-1:0], shadow.v2v5[LO-1:0]};
	wire [7:0] ext2_val = {6'h00, shadow.v12[LO-1:0]};

	// Read selection; unmapped and reserved bits read as zero
	wire [7:0] hyst_rd = {7'h00, hyst_cfg[fmc_pkg::HB_HYST_DIS]}; // R12
	wire [7:0] cfg1_rd = {6'h00, lock, 1'b0};
	wire [7:0] stat_rd = {6'h00, stat_core, 1'b0};
	wire [7:0] mask_rd = {6'h00, mask_core, 1'b0};
	wire [7:0] rd_value =
		hit_fan   ? fan_cfg  :
		hit_hyst  ? hyst_rd  :
		hit_v2v5  ? msb_v2v5 :
		hit_vcore ? msb_core :
		hit_vsup  ? msb_sup  :
		hit_v5    ? msb_v5   :
		hit_v12   ? msb_v12  :
		hit_cfg1  ? cfg1_rd  :
		hit_stat  ? stat_rd  :
		hit_lim   ? core_lim :
		hit_mask  ? mask_rd  :
		hit_ext1  ? ext1_val :
		hit_ext2  ? ext2_val :
		fmc_pkg::RST_BYTE; // R15

	// Core voltage watch on the live measurement
	wire [7:0] core_now = MEAS.core[HI:LO];
	wire core_below = core_now < core_lim;
	wire core_above = core_now > core_lim;
	wire core_enter = (core_state == fmc_pkg::FMC_CORE_OK) & fan_cfg[fmc_pkg::FB_CORE_LOW] &
		STANDBY_POWER & core_below; // R07
	wire core_leave = (core_state == fmc_pkg::FMC_CORE_LOW) & core_above; // R08
	wire next_stat = (stat_core & ~rd_stat) | core_enter; // R07

	// Overtemp pin stays live under manual duty only when asked
	wire pin_active = ~FAN_MANUAL | fan_cfg[fmc_pkg::FB_PIN_MAN]; // R04
	wire next_force = OVERTEMP_EVENT & pin_active; // R10

	// Bus handshake: writes take no wait, reads one wait state so a read
	// straight after a write always sees the written value
	always_ff @(posedge CLK) begin
		if (RESET) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			idx_q <= '0;
			mapped_q <= 1'b0;
			HREADYOUT <= 1'b1;
			HRESP <= fmc_pkg::HRESP_OKAY;
			HRDATA <= '0;
		end else begin
			wr_pend <= acc_write;
			rd_pend <= acc_read;
			if (addr_acc) begin
				idx_q <= addr_idx;
				mapped_q <= addr_mapped;
			end
			HREADYOUT <= ~acc_read;
			HRESP <= fmc_pkg::HRESP_OKAY;
			if (rd_pend) begin
				HRDATA <= {24'h000000, rd_value};
			end
		end
	end

	// Configuration registers; lock is write-once and only reset clears it
	always_ff @(posedge CLK) begin
		if (RESET) begin
			fan_cfg <= fmc_pkg::RST_BYTE; // R14
			hyst_cfg <= fmc_pkg::RST_BYTE;
			lock <= 1'b0;
			core_lim <= fmc_pkg::RST_CORE_LIM;
			mask_core <= 1'b0;
		end else begin
			if (we_fan) begin
				fan_cfg <= wbyte;
			end
			if (we_hyst) begin
				hyst_cfg <= {7'h00, wbyte[fmc_pkg::HB_HYST_DIS]}; // R11 R12
			end
			lock <= lock | (we_cfg1 & wbyte[fmc_pkg::C1B_LOCK]); // R17
			if (we_lim) begin
				core_lim <= wbyte;
			end
			if (we_mask) begin
				mask_core <= wbyte[fmc_pkg::STB_CORE];
			end
		end
	end

	// Measurement snapshot and freeze bookkeeping
	always_ff @(posedge CLK) begin
		if (RESET) begin
			shadow <= '0;
			pend_mask <= '0;
		end else begin
			shadow <= next_shadow; // R16
			pend_mask <= next_pend;
		end
	end

	// Core-low sleep machine; the status flag is cleared by reading it, set wins
	always_ff @(posedge CLK) begin
		if (RESET) begin
			core_state <= fmc_pkg::FMC_CORE_OK;
			stat_core <= 1'b0;
			PROC_HOT_MONITOR_EN <= 1'b1;
			SPINUP_REQ <= 1'b0;
			ALERT <= 1'b0;
		end else begin
			stat_core <= next_stat;
			ALERT <= stat_core & ~mask_core; // R07
			SPINUP_REQ <= core_leave; // R08
			unique case (core_state)
				fmc_pkg::FMC_CORE_OK: begin
					if (core_enter) begin
						core_state <= fmc_pkg::FMC_CORE_LOW;
						PROC_HOT_MONITOR_EN <= 1'b0; // R07
					end
				end
				fmc_pkg::FMC_CORE_LOW: begin
					if (core_leave) begin
						core_state <= fmc_pkg::FMC_CORE_OK;
						PROC_HOT_MONITOR_EN <= 1'b1; // R08
					end
				end
			endcase
		end
	end

	// Mode outputs, registered so the pins never glitch on a bus write
	always_ff @(posedge CLK) begin
		if (RESET) begin
			OVERTEMP_PIN_ACTIVE <= 1'b1;
			OVERTEMP_HYST_DISABLE <= 1'b0;
			FAN_FORCE_MAX <= 1'b0;
			SYNC_FOLLOWER <= 1'b0;
			SYNC_LEADER <= 1'b0;
		end else begin
			OVERTEMP_PIN_ACTIVE <= pin_active; // R04
			OVERTEMP_HYST_DISABLE <= hyst_cfg[fmc_pkg::HB_HYST_DIS]; // R11
			FAN_FORCE_MAX <= next_force; // R10
			SYNC_FOLLOWER <= fan_cfg[fmc_pkg::FB_FOLLOWER]; // R05
			SYNC_LEADER <= fan_cfg[fmc_pkg::FB_LEADER]; // R06
		end
	end

	// Smoothing time per fan: x4 by its own bit, then the common stretch
	localparam int unsigned X4_W = BASE_W + fmc_pkg::X4_SHIFT;
	localparam int unsigned PROD_W = X4_W + fmc_pkg::STR_NUM_W;
	for (genvar i = 0; i < fmc_pkg::FAN_N; i++) begin : g_fan
		wire slow = fan_cfg[fmc_pkg::FB_SLOW_RA + i]; // R01 R02 R03
		wire [X4_W-1:0] x4_val = slow ? {BASE_SMOOTH[i], {fmc_pkg::X4_SHIFT{1'b0}}} :
			{{fmc_pkg::X4_SHIFT{1'b0}}, BASE_SMOOTH[i]}; // R01 R02 R03
		wire [PROD_W-1:0] prod = PROD_W'(x4_val) * PROD_W'(fmc_pkg::STR_NUM); // R09
		wire [OUT_W-1:0] plain = OUT_W'(x4_val);
		// Truncating the product trades a fraction of a tick for no divider
		wire [OUT_W-1:0] next_time = fan_cfg[fmc_pkg::FB_STRETCH] ?
			prod[fmc_pkg::STR_SHIFT +: OUT_W] : plain; // R09
		always_ff @(posedge CLK) begin
			if (RESET) begin
				SMOOTH_TIME[i] <= '0;
			end else begin
				SMOOTH_TIME[i] <= next_time;
			end
		end

		AST_SMOOTH_SCALE: assert property (@(posedge CLK) disable iff (RESET) // R01 R02 R03
			!fan_cfg[fmc_pkg::FB_STRETCH] ##1 !fan_cfg[fmc_pkg::FB_STRETCH] |->
			SMOOTH_TIME[i] == ($past(fan_cfg[fmc_pkg::FB_SLOW_RA + i]) ?
			OUT_W'({$past(BASE_SMOOTH[i]), {fmc_pkg::X4_SHIFT{1'b0}}}) : OUT_W'($past(BASE_SMOOTH[i]))))
			else $error("fan smoothing x4 scaling wrong");
	end

	// Checks
	AST_LOCK_BLOCKS: assert property (@(posedge CLK) disable iff (RESET) // R13
		(wr_pend & hit_hyst & lock) |=> $stable(hyst_cfg))
		else $error("locked hysteresis register changed");
	AST_LOCK_STICKY: assert property (@(posedge CLK) disable iff (RESET) // R17
		lock |=> lock [*8])
		else $error("lock bit cleared without reset");
	AST_FAN_RESET: assert property (@(posedge CLK) // R14
		$past(RESET) |-> fan_cfg == fmc_pkg::RST_BYTE && !SYNC_LEADER && !SYNC_FOLLOWER)
		else $error("fan config not zero after reset");
	AST_HYST_WRITE: assert property (@(posedge CLK) disable iff (RESET) // R11
		(wr_pend & hit_hyst & !lock) |=> ##1 OVERTEMP_HYST_DISABLE == $past(HWDATA[0], 2))
		else $error("hysteresis disable not following write");
	AST_STRETCH: assert property (@(posedge CLK) disable iff (RESET) // R09
		fan_cfg[fmc_pkg::FB_STRETCH] && !fan_cfg[0] ##1 fan_cfg[fmc_pkg::FB_STRETCH] |->
		SMOOTH_TIME[0] == OUT_W'((PROD_W'($past(BASE_SMOOTH[0])) * fmc_pkg::STR_NUM) >> fmc_pkg::STR_SHIFT))
		else $error("extra stretch not 1425/1024");
	AST_CORE_ENTER: assert property (@(posedge CLK) disable iff (RESET) // R07
		core_enter |=> stat_core && !PROC_HOT_MONITOR_EN ##1 (ALERT == !mask_core))
		else $error("core low entry effects missing");
	AST_CORE_LEAVE: assert property (@(posedge CLK) disable iff (RESET) // R08
		core_leave |=> PROC_HOT_MONITOR_EN && SPINUP_REQ ##1 !SPINUP_REQ)
		else $error("core recovery effects missing");
	AST_FREEZE_HOLD: assert property (@(posedge CLK) disable iff (RESET) // R16
		(rd_ext1 | frozen) |=> $stable(shadow))
		else $error("readings moved while frozen");
	AST_FREEZE_END: assert property (@(posedge CLK) disable iff (RESET) // R16
		(rd_pend && !rd_ext1 && !rd_ext2) |=> (pend_mask & $past(rd_msb)) == '0)
		else $error("upper byte read did not release freeze");
	AST_FORCE_MAX: assert property (@(posedge CLK) disable iff (RESET) // R10
		OVERTEMP_EVENT && (!FAN_MANUAL || fan_cfg[fmc_pkg::FB_PIN_MAN]) |=> FAN_FORCE_MAX)
		else $error("overtemp did not force fans");
	AST_READ_WAIT: assert property (@(posedge CLK) disable iff (RESET) // R15
		acc_read |=> !HREADYOUT ##1 HREADYOUT && HRDATA[31:8] == 24'h000000)
		else $error("read handshake wrong");

	COV_LOCK_SET: cover property (@(posedge CLK) disable iff (RESET) !lock ##1 lock);
	COV_CORE_CYCLE: cover property (@(posedge CLK) disable iff (RESET) core_enter ##[1:200] core_leave);
	COV_FREEZE: cover property (@(posedge CLK) disable iff (RESET) rd_ext1 ##[1:50] (rd_pend && hit_vcore));
	COV_LOCKED_WRITE: cover property (@(posedge CLK) disable iff (RESET) wr_pend && hit_hyst && lock);

endmodule // fmc_top

/* File: testbench/fmc_host.sv */
// Management bus host model: single-word AHB-Lite transfers
`timescale 1ns/1ps
module fmc_host (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	// Bus idles until the first transfer
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h5A5A5A5A;
	end

	// Each phase is held until hready is seen high; reads drive fresh junk on hwdata
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0}; // Index times four
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? wd : ~hwdata;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
endmodule // fmc_host

/* File: testbench/test_fan_monitor_config_readings.sv */
// Self-checking bench of the fan monitor register bank
`timescale 1ns/1ps
module test_fan_monitor_config_readings;
	localparam int unsigned BW = 16;
	localparam int unsigned OW = BW + 3;
	logic                           clk;
	logic                           reset;
	logic                           hsel;
	logic [31:0]                    haddr;
	logic [1:0]                     htrans;
	logic                           hwrite;
	logic [2:0]                     hsize;
	logic [31:0]                    hwdata;
	logic [31:0]                    hrdata;
	logic                           hreadyout;
	logic                           hresp;
	fmc_pkg::fmc_meas_t             meas;
	logic                           standby;
	logic                           manual;
	logic                           ot_event;
	logic [2:0][BW-1:0]             base;
	logic [2:0][OW-1:0]             smooth;
	logic                           pin_act;
	logic                           hyst_dis;
	logic                           force_max;
	logic                           follower;
	logic                           leader;
	logic                           hot_en;
	logic                           spinup;
	logic                           alert;
	logic [31:0]                    rd;
	logic [7:0]                     c;
	logic [2:0][BW-1:0]             b;
	logic                           man;
	logic                           ev;
	int                             m[5];
	int                             om[5];
	int                             spins;
	int                             errors;
	int                             checks_done;

	fmc_top #(.BASE_W(BW)) dut (.CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .MEAS(meas), .STANDBY_POWER(standby), .FAN_MANUAL(manual),
		.OVERTEMP_EVENT(ot_event), .BASE_SMOOTH(base), .SMOOTH_TIME(smooth), .OVERTEMP_PIN_ACTIVE(pin_act),
		.OVERTEMP_HYST_DISABLE(hyst_dis), .FAN_FORCE_MAX(force_max), .SYNC_FOLLOWER(follower),
		.SYNC_LEADER(leader), .PROC_HOT_MONITOR_EN(hot_en), .SPINUP_REQ(spinup), .ALERT(alert));

	fmc_host host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// One compare, counted; mismatches reported at once
	task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, got);
		end
	endtask

	// Bus helpers; every read also checks the OKAY response
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		host.xfer(1'b1, idx, d, rd);
	endtask

	task automatic rdc(input string n, input logic [7:0] idx, input logic [31:0] e);
		host.xfer(1'b0, idx, 32'h0, rd);
		check(n, rd, e);
		check("resp", hresp, 1'b0);
	endtask

	// Let registered outputs land, then sample clear of the edge
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// New random measurement set, kept in the model array too
	task automatic set_meas();
		@(posedge clk);
		foreach (m[i]) m[i] = $urandom % 1024;
		meas <= {10'(m[4]), 10'(m[3]), 10'(m[2]), 10'(m[1]), 10'(m[0])};
	endtask

	// Model of the smoothing scale: x4, then the truncated stretch ratio
	function automatic longint exp_smooth(input logic x4, input logic st, input longint bv);
		longint v;
		v = x4 ? bv * 4 : bv;
		if (st) v = (v * fmc_pkg::STR_NUM) >> fmc_pkg::STR_SHIFT;
		return v;
	endfunction

	// Verdict in one place
	task automatic close_out();
		$display("Totals: %0d mismatches in %0d checks", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog sized well beyond the whole sequence
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out();
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		meas = '0;
		standby = 1'b0;
		manual = 1'b0;
		ot_event = 1'b0;
		base = '0;
		errors = 0;
		checks_done = 0;
		void'($urandom(17050));
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		settle(1);
		check("hot_en", hot_en, 1'b1);
		rdc("fan_cfg", fmc_pkg::IDX_FAN_CFG, 32'h0);
		rdc("hyst", fmc_pkg::IDX_HYST_CFG, 32'h0);
		$display("test reset done");
		// Random configurations against the scaling and mode model
		for (int k = 0; k < 12; k++) begin
			c = 8'($urandom);
			b = 48'({$urandom, $urandom});
			man = 1'($urandom);
			ev = 1'($urandom);
			@(posedge clk);
			base <= b;
			manual <= man;
			ot_event <= ev;
			wr(fmc_pkg::IDX_FAN_CFG, {24'h0, c});
			settle(3);
			for (int i = 0; i < 3; i++)
				check("smooth", 32'(smooth[i]), 32'(exp_smooth(c[i], c[7], longint'(b[i]))));
			check("follower", follower, c[4]);
			check("leader", leader, c[5]);
			check("pin", pin_act, !man | c[3]);
			check("force", force_max, ev & (!man | c[3]));
			rdc("fan_cfg", fmc_pkg::IDX_FAN_CFG, {24'h0, c});
		end
		$display("test config done");
		// Hysteresis control; only bit 0 is ever written
		wr(fmc_pkg::IDX_HYST_CFG, 32'h1);
		settle(2);
		check("hyst_dis", hyst_dis, 1'b1);
		rdc("hyst", fmc_pkg::IDX_HYST_CFG, 32'h1);
		wr(fmc_pkg::IDX_HYST_CFG, 32'h0);
		$display("test hysteresis done");
		// Upper bytes of all five readings, plus an unmapped place
		set_meas();
		settle(2);
		for (int i = 0; i < 5; i++)
			rdc("volt", 8'(fmc_pkg::IDX_V2V5 + i), m[i] >> 2);
		rdc("unmapped", 8'h30, 32'h0);
		$display("test readings done");
		// Extended read first freezes the set until the upper bytes are read
		om = m;
		rdc("ext1", fmc_pkg::IDX_EXT1, {24'h0, 2'(om[3]), 2'(om[2]), 2'(om[1]), 2'(om[0])});
		set_meas();
		settle(2);
		for (int i = 0; i < 4; i++)
			rdc("frozen", 8'(fmc_pkg::IDX_V2V5 + i), om[i] >> 2);
		rdc("thawed", fmc_pkg::IDX_V2V5, m[0] >> 2);
		$display("test freeze done");
		// Core voltage drops under its limit on standby power, then recovers
		wr(fmc_pkg::IDX_CORE_LIM, 32'h80);
		@(posedge clk);
		meas.core <= 10'h100;
		standby <= 1'b1;
		wr(fmc_pkg::IDX_FAN_CFG, 32'h40);
		settle(3);
		check("hot_en", hot_en, 1'b0);
		check("alert", alert, 1'b1);
		rdc("status", fmc_pkg::IDX_STAT1, 32'h2);
		@(posedge clk);
		meas.core <= 10'h3FC;
		spins = 0;
		repeat (8) begin
			settle(1);
			spins += int'(spinup);
		end
		check("spinup", 32'(spins), 32'h1);
		check("hot_en", hot_en, 1'b1);
		$display("test core low done");
		// Lock blocks later writes to lockable registers
		wr(fmc_pkg::IDX_CFG1, 32'h2);
		wr(fmc_pkg::IDX_HYST_CFG, 32'h1);
		settle(2);
		check("hyst_dis", hyst_dis, 1'b0);
		rdc("hyst", fmc_pkg::IDX_HYST_CFG, 32'h0);
		wr(fmc_pkg::IDX_CORE_LIM, 32'h0);
		rdc("limit", fmc_pkg::IDX_CORE_LIM, 32'h80);
		rdc("lock", fmc_pkg::IDX_CFG1, 32'h2);
		$display("test lock done");
		// Masked core-low entry keeps the alert quiet but still stops hot monitoring
		wr(fmc_pkg::IDX_MASK1, 32'h2);
		rdc("mask", fmc_pkg::IDX_MASK1, 32'h2);
		@(posedge clk);
		meas.core <= 10'h100;
		settle(3);
		check("hot_en", hot_en, 1'b0);
		check("alert", alert, 1'b0);
		rdc("status", fmc_pkg::IDX_STAT1, 32'h2);
		@(posedge clk);
		meas.core <= 10'h3FC;
		standby <= 1'b0; // Random readings below must not re-enter core low
		settle(2);
		check("hot_en", hot_en, 1'b1);
		$display("test masked alert done");
		// Second extended register freezes all readings until the 12 V upper byte is read
		set_meas();
		settle(2);
		om = m;
		rdc("ext2", fmc_pkg::IDX_EXT2, {30'h0, 2'(om[4])});
		set_meas();
		settle(2);
		rdc("frozen12", fmc_pkg::IDX_V12, om[4] >> 2);
		rdc("thawed12", fmc_pkg::IDX_V12, m[4] >> 2);
		$display("test second extended done");
		close_out();
	end
endmodule // test_fan_monitor_config_readings
